// ---- hw/lcd_decoder_regs.svh ----
/*
  Command codes, parameter field positions, reset values and timing constants
  of the LCD command decoder. Definitions only; included by its bare name.
*/
`ifndef LCD_DECODER_REGS_SVH
`define LCD_DECODER_REGS_SVH

// command bytes
`define CMD_SOFT_RESET 8'hAA
`define CMD_WR_PAGE0 8'h80
`define CMD_RD_PAGE0 8'h81
`define CMD_WR_PAGE1 8'h70
`define CMD_RD_PAGE1 8'h71
`define CMD_PAGE_SEL 8'h72
`define CMD_DRIVE_MODE 8'h82
`define CMD_WAVEFORM 8'h84
`define CMD_SYS_MODE 8'h86
`define CMD_FRAME_RATE 8'h88
`define CMD_BLINK 8'h8A
`define CMD_GPO_DATA 8'h90
`define CMD_OUT_FUNC 8'h92
`define CMD_PWM_EN 8'hB0
`define CMD_PWM0 8'hB2
`define CMD_PWM1 8'hB4
`define CMD_PWM2 8'hB6
`define CMD_PWM3 8'hB8
`define CMD_PUMP_IN 8'hC0
`define CMD_PUMP_CTRL 8'hC2
`define CMD_BIAS_CIRC 8'hD0
`define CMD_CONTRAST 8'hD2
`define CMD_BIAS_RES 8'hD4

// field positions
`define SYS_OSC_BIT 1
`define SYS_DISP_BIT 0
`define PUMP_SRC_BIT 7
`define REG_EN_BIT 6
`define PUMP_EN_BIT 7
`define LCD_SUPPLY_BIT 4
`define BIAS_CIRC_BAD 2'h2

// reset values
`define RST_DRIVE_MODE 8'hF7
`define RST_FRAME_RATE 4'hA
`define RST_BIAS_RES 2'h2

// timing
`define CLK_HZ 100_000_000
`define PWM_STEPS 64
`endif

// ---- hw/lcd_decoder_pkg.sv ----
/*
  Types shared by the LCD command decoder.
  Assumes nothing of its surroundings.
*/
package lcd_decoder_pkg;
  typedef enum logic [2:0] {
    S_CMD = 3'b000,
    S_PARAM = 3'b001,
    S_ADDR = 3'b010,
    S_WDATA = 3'b011,
    S_RDATA = 3'b100,
    S_IGNORE = 3'b101
  } dec_state_t;
endpackage

// ---- hw/lcd_display_ram.sv ----
/*
  Two-page display RAM: one read/write port for the host, one read port for
  the display scan. Both read data come out of a register.
  Assumes a single clock; contents are not cleared by reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_display_ram #(
  parameter int AW = 9
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr_a,
  input wire logic [7:0] wdata_a,
  output logic [7:0] rdata_a,
  input wire logic [AW-1:0] addr_b,
  output logic [7:0] rdata_b
);
  logic [7:0] mem [0:(1<<AW)-1];

  // write-first is not needed: host never reads and writes in one cycle
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr_a] <= wdata_a;
    end
    rdata_a <= mem[addr_a];
    rdata_b <= mem[addr_b];
  end
endmodule
`default_nettype wire

// ---- hw/lcd_gpo_pwm.sv ----
/*
  General output stage: binary level or 64-step PWM per pin.
  Assumes settings come from flip-flops on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcd_decoder_regs.svh"
module lcd_gpo_pwm (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_on,
  input wire logic [3:0] frame_code,
  input wire logic [3:0] mode_sel,
  input wire logic [3:0] pwm_en,
  input wire logic [3:0] gpo_data,
  input wire logic [23:0] duty,
  output logic [3:0] gpo
);
  // clocks per pwm step for each frame rate code
  function automatic logic [15:0] step_div(input logic [3:0] code);
    int hz;
    case (code)
      4'h0: hz = 800;
      4'h1: hz = 960;
      4'h2: hz = 1120;
      4'h3: hz = 1280;
      4'h4: hz = 1440;
      4'h5: hz = 1600;
      4'h6: hz = 1920;
      4'h7: hz = 2240;
      4'h8: hz = 2560;
      4'h9: hz = 2880;
      4'hA: hz = 3200;
      4'hB: hz = 3520;
      4'hC: hz = 3840;
      4'hD: hz = 4160;
      4'hE: hz = 4480;
      default: hz = 4800;
    endcase
    return 16'(`CLK_HZ / (hz * `PWM_STEPS));
  endfunction

  logic [15:0] div_q;
  logic [5:0] step_q;
  logic [3:0] gpo_d;
  wire tick = (div_q >= step_div(frame_code) - 16'h0001);

  // step counter held at zero while the oscillator is off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= 16'h0000;
      step_q <= 6'h00;
    end else if (!osc_on) begin
      div_q <= 16'h0000;
      step_q <= 6'h00;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
      step_q <= tick ? step_q + 6'h01 : step_q;
    end
  end

  // high for duty+1 of 64 steps; pwm dies with the oscillator
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      gpo_d[n] = mode_sel[n] ? (pwm_en[n] && osc_on && step_q <= duty[n*6 +: 6])
                             : gpo_data[n];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpo <= 4'h0;
    end else begin
      gpo <= gpo_d;
    end
  end

  full_on_a: assert property (@(posedge clk) disable iff (rst)
    mode_sel[0] && pwm_en[0] && osc_on && duty[5:0] == 6'h3F |=> gpo[0])
    else $error("pwm full duty not high");
endmodule
`default_nettype wire

// ---- hw/lcd_driver_command_decoder.sv ----
/*
  Command decoder and settings store of the LCD controller driver: serial
  byte receiver, command sequencer, settings, RAM access and GPO stage.
  Assumes a 3-wire serial host, link pins asynchronous to I_REF_CLK, and
  the link clock well below a quarter of I_REF_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcd_decoder_regs.svh"
// Contract
// - soft reset command restores all power-on values
// - page 0 write: command, address, data
// - out-of-range address write leaves RAM untouched
// - page 0 read: command, address, data out
// - page 1 uses own codes, same sequence
// - page select bit picks displayed page
// - duty code in bits 7:4, default F7h
// - bias code bits 2:0, bit2 means fifth
// - waveform select bit 0, A or B
// - oscillator bit 1, display bit 0
// - four bit frame rate code, default 0Ah
// - two bit blink code, default zero
// - gpo data bits drive pins directly
// - per-pin output mode select, default zero
// - per-pin pwm enable, default zero
// - six bit pwm duty per output
// - pump source, regulator enable and level
// - pump enable and pump ratio
// - lcd supply select and bias circuit code
// - contrast code and bias resistor code
// - undefined parameter values change nothing; code drops only bias circuit code 2 and still takes the supply bit
// - oscillator off blanks display, stops pwm
// - pwm high for duty plus one steps
// - mode bit chooses binary or pwm
module lcd_driver_command_decoder #(
  parameter int RAM_AW = 9
) (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESET,
  // serial link
  input wire logic i_CS_N,
  input wire logic i_LINK_CLK,
  input wire logic i_LINK_DIO,
  output logic o_LINK_DIO,
  output logic o_LINK_DIO_OE,
  // display scan
  input wire logic [7:0] i_SCAN_ADDR,
  output logic [7:0] o_SCAN_DATA,
  // lcd settings
  output logic o_PAGE_SELECT,
  output logic [3:0] o_DUTY_CODE,
  output logic [2:0] o_BIAS_CODE,
  output logic o_WAVEFORM_SELECT,
  output logic o_OSC_ON,
  output logic o_DISPLAY_ON,
  output logic o_LCD_ACTIVE,
  output logic [3:0] o_FRAME_RATE_CODE,
  output logic [1:0] o_BLINK_CODE,
  // general outputs
  output logic [3:0] o_GENERAL_OUTPUT,
  // analog controls
  output logic o_PUMP_SOURCE_SELECT,
  output logic o_REGULATOR_ENABLE,
  output logic [4:0] o_REGULATOR_LEVEL,
  output logic o_PUMP_ENABLE,
  output logic [2:0] o_PUMP_RATIO,
  output logic o_LCD_SUPPLY_SELECT,
  output logic [1:0] o_BIAS_CIRCUIT_CODE,
  output logic [3:0] o_CONTRAST_CODE,
  output logic [1:0] o_BIAS_RESISTOR_CODE
);
  if (RAM_AW != 9) begin : g_bad_aw
    $error("RAM_AW must be 9: page bit plus 8-bit address");
  end

  // highest writable address for a duty code
  function automatic logic [7:0] max_addr(input logic [3:0] duty);
    case (duty)
      4'hF: return 8'h77;
      4'hE: return 8'h79;
      4'hD: return 8'h7B;
      4'hC: return 8'h7D;
      4'hB: return 8'h7F;
      4'hA: return 8'h81;
      4'h9: return 8'h83;
      4'h8: return 8'h85;
      4'h7: return 8'h43;
      4'h6: return 8'h44;
      4'h5: return 8'h45;
      4'h4: return 8'h46;
      default: return 8'h47;
    endcase
  endfunction

  // pin synchronisers
  logic cs_meta_q, cs_q, clk_meta_q, clk_q, clk_prev_q, dio_meta_q, dio_q;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cs_meta_q <= 1'b1;
      cs_q <= 1'b1;
      clk_meta_q <= 1'b0;
      clk_q <= 1'b0;
      clk_prev_q <= 1'b0;
      dio_meta_q <= 1'b0;
      dio_q <= 1'b0;
    end else begin
      cs_meta_q <= i_CS_N;
      cs_q <= cs_meta_q;
      clk_meta_q <= i_LINK_CLK;
      clk_q <= clk_meta_q;
      clk_prev_q <= clk_q;
      dio_meta_q <= i_LINK_DIO;
      dio_q <= dio_meta_q;
    end
  end

  wire cs_act = ~cs_q;
  wire rise = cs_act && clk_q && !clk_prev_q;

  // byte assembly, msb first, on link clock rising edges
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  wire [7:0] byte_in = {shift_q, dio_q};
  wire byte_done = rise && bit_cnt_q == 3'h7;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
    end else if (!cs_act) begin
      bit_cnt_q <= 3'h0;
    end else if (rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= byte_in[6:0];
    end
  end

  // command classification of the first byte
  lcd_decoder_pkg::dec_state_t state_q, state_d;
  logic [7:0] cmd_q, addr_q;
  logic rd_mode_q, acc_page_q;
  wire is_cmd = byte_done && state_q == lcd_decoder_pkg::S_CMD;
  wire is_wr = byte_in == `CMD_WR_PAGE0 || byte_in == `CMD_WR_PAGE1;
  wire is_rd = byte_in == `CMD_RD_PAGE0 || byte_in == `CMD_RD_PAGE1;
  wire is_p1 = byte_in == `CMD_WR_PAGE1 || byte_in == `CMD_RD_PAGE1;
  wire soft_rst = is_cmd && byte_in == `CMD_SOFT_RESET;
  wire param_done = byte_done && state_q == lcd_decoder_pkg::S_PARAM;

  logic is_param;
  always_comb begin
    case (byte_in)
      `CMD_PAGE_SEL, `CMD_DRIVE_MODE, `CMD_WAVEFORM, `CMD_SYS_MODE,
      `CMD_FRAME_RATE, `CMD_BLINK, `CMD_GPO_DATA, `CMD_OUT_FUNC,
      `CMD_PWM_EN, `CMD_PWM0, `CMD_PWM1, `CMD_PWM2, `CMD_PWM3,
      `CMD_PUMP_IN, `CMD_PUMP_CTRL, `CMD_BIAS_CIRC, `CMD_CONTRAST,
      `CMD_BIAS_RES: is_param = 1'b1;
      default: is_param = 1'b0;
    endcase
  end

  // sequencer: unknown bytes and trailing bytes are swallowed until cs ends
  always_comb begin
    state_d = state_q;
    case (state_q)
      lcd_decoder_pkg::S_CMD: begin
        if (byte_done) begin
          state_d = (is_wr || is_rd) ? lcd_decoder_pkg::S_ADDR
                  : is_param ? lcd_decoder_pkg::S_PARAM : lcd_decoder_pkg::S_IGNORE;
        end
      end
      lcd_decoder_pkg::S_ADDR: begin
        if (byte_done) begin
          state_d = rd_mode_q ? lcd_decoder_pkg::S_RDATA : lcd_decoder_pkg::S_WDATA;
        end
      end
      lcd_decoder_pkg::S_PARAM, lcd_decoder_pkg::S_WDATA, lcd_decoder_pkg::S_RDATA: begin
        if (byte_done) begin
          state_d = lcd_decoder_pkg::S_IGNORE;
        end
      end
      lcd_decoder_pkg::S_IGNORE: state_d = lcd_decoder_pkg::S_IGNORE;
      default: state_d = lcd_decoder_pkg::S_IGNORE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= lcd_decoder_pkg::S_CMD;
      cmd_q <= 8'h00;
      addr_q <= 8'h00;
      rd_mode_q <= 1'b0;
      acc_page_q <= 1'b0;
    end else if (!cs_act) begin
      state_q <= lcd_decoder_pkg::S_CMD;
    end else begin
      state_q <= state_d;
      if (is_cmd) begin
        cmd_q <= byte_in;
        rd_mode_q <= is_rd;
        acc_page_q <= is_p1;
      end
      if (byte_done && state_q == lcd_decoder_pkg::S_ADDR) begin
        addr_q <= byte_in;
      end
    end
  end

  // settings; each updates when its parameter byte completes
  logic page_select_q, waveform_q, osc_on_q, display_on_q, lcd_active_q;
  logic [7:0] drive_q;
  logic [3:0] frame_q, gpo_data_q, mode_sel_q, pwm_en_q, contrast_q;
  logic [1:0] blink_q, bias_circ_q, bias_res_q;
  logic [23:0] pwm_duty_q;
  logic pump_src_q, reg_en_q, pump_en_q, lcd_supply_q;
  logic [4:0] reg_level_q;
  logic [2:0] pump_ratio_q;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET || soft_rst) begin
      page_select_q <= 1'b0;
      drive_q <= `RST_DRIVE_MODE;
      waveform_q <= 1'b0;
      osc_on_q <= 1'b0;
      display_on_q <= 1'b0;
      frame_q <= `RST_FRAME_RATE;
      blink_q <= 2'h0;
      gpo_data_q <= 4'h0;
      mode_sel_q <= 4'h0;
      pwm_en_q <= 4'h0;
      pwm_duty_q <= 24'h00_0000;
      pump_src_q <= 1'b0;
      reg_en_q <= 1'b0;
      reg_level_q <= 5'h00;
      pump_en_q <= 1'b0;
      pump_ratio_q <= 3'h0;
      lcd_supply_q <= 1'b0;
      bias_circ_q <= 2'h0;
      contrast_q <= 4'h0;
      bias_res_q <= `RST_BIAS_RES;
    end else if (param_done) begin
      case (cmd_q)
        `CMD_PAGE_SEL: page_select_q <= byte_in[0];
        `CMD_DRIVE_MODE: drive_q <= {byte_in[7:4], 1'b0, byte_in[2:0]};
        `CMD_WAVEFORM: waveform_q <= byte_in[0];
        `CMD_SYS_MODE: begin
          osc_on_q <= byte_in[`SYS_OSC_BIT];
          display_on_q <= byte_in[`SYS_DISP_BIT];
        end
        `CMD_FRAME_RATE: frame_q <= byte_in[3:0];
        `CMD_BLINK: blink_q <= byte_in[1:0];
        `CMD_GPO_DATA: gpo_data_q <= byte_in[3:0];
        `CMD_OUT_FUNC: mode_sel_q <= byte_in[3:0];
        `CMD_PWM_EN: pwm_en_q <= byte_in[3:0];
        `CMD_PWM0: pwm_duty_q[5:0] <= byte_in[5:0];
        `CMD_PWM1: pwm_duty_q[11:6] <= byte_in[5:0];
        `CMD_PWM2: pwm_duty_q[17:12] <= byte_in[5:0];
        `CMD_PWM3: pwm_duty_q[23:18] <= byte_in[5:0];
        `CMD_PUMP_IN: begin
          pump_src_q <= byte_in[`PUMP_SRC_BIT];
          reg_en_q <= byte_in[`REG_EN_BIT];
          reg_level_q <= byte_in[4:0];
        end
        `CMD_PUMP_CTRL: begin
          pump_en_q <= byte_in[`PUMP_EN_BIT];
          pump_ratio_q <= byte_in[6:4];
        end
        `CMD_BIAS_CIRC: begin
          lcd_supply_q <= byte_in[`LCD_SUPPLY_BIT];
          if (byte_in[1:0] != `BIAS_CIRC_BAD) begin
            bias_circ_q <= byte_in[1:0];
          end
        end
        `CMD_CONTRAST: contrast_q <= byte_in[3:0];
        `CMD_BIAS_RES: bias_res_q <= byte_in[1:0];
        default: ;
      endcase
    end
  end

  // display drives only with oscillator and display both on
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      lcd_active_q <= 1'b0;
    end else begin
      lcd_active_q <= osc_on_q && display_on_q;
    end
  end

  // ram access: write gated by the duty-dependent limit
  wire addr_ok = addr_q <= max_addr(drive_q[7:4]);
  wire ram_we = byte_done && state_q == lcd_decoder_pkg::S_WDATA && addr_ok;
  wire [7:0] ram_addr = ram_we ? addr_q : byte_in;
  wire [7:0] ram_rdata;
  logic load_q;

  lcd_display_ram #(.AW(RAM_AW)) u_ram (
    .clk(I_REF_CLK),
    .we(ram_we),
    .addr_a({acc_page_q, ram_addr}),
    .wdata_a(byte_in),
    .rdata_a(ram_rdata),
    .addr_b({page_select_q, i_SCAN_ADDR}),
    .rdata_b(o_SCAN_DATA)
  );

  // read data goes out msb first, shifted after each sampled rising edge
  logic [7:0] tx_q;
  logic oe_q;
  always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      load_q <= 1'b0;
      tx_q <= 8'h00;
      oe_q <= 1'b0;
    end else begin
      load_q <= byte_done && state_q == lcd_decoder_pkg::S_ADDR && rd_mode_q;
      if (load_q) begin
        tx_q <= ram_rdata;
      end else if (rise && state_q == lcd_decoder_pkg::S_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
      oe_q <= cs_act && state_q == lcd_decoder_pkg::S_RDATA;
    end
  end

  lcd_gpo_pwm u_gpo (
    .clk(I_REF_CLK),
    .rst(I_RESET),
    .osc_on(osc_on_q),
    .frame_code(frame_q),
    .mode_sel(mode_sel_q),
    .pwm_en(pwm_en_q),
    .gpo_data(gpo_data_q),
    .duty(pwm_duty_q),
    .gpo(o_GENERAL_OUTPUT)
  );

  // outputs straight from flip-flops
  assign o_LINK_DIO = tx_q[7];
  assign o_LINK_DIO_OE = oe_q;
  assign o_PAGE_SELECT = page_select_q;
  assign o_DUTY_CODE = drive_q[7:4];
  assign o_BIAS_CODE = drive_q[2:0];
  assign o_WAVEFORM_SELECT = waveform_q;
  assign o_OSC_ON = osc_on_q;
  assign o_DISPLAY_ON = display_on_q;
  assign o_LCD_ACTIVE = lcd_active_q;
  assign o_FRAME_RATE_CODE = frame_q;
  assign o_BLINK_CODE = blink_q;
  assign o_PUMP_SOURCE_SELECT = pump_src_q;
  assign o_REGULATOR_ENABLE = reg_en_q;
  assign o_REGULATOR_LEVEL = reg_level_q;
  assign o_PUMP_ENABLE = pump_en_q;
  assign o_PUMP_RATIO = pump_ratio_q;
  assign o_LCD_SUPPLY_SELECT = lcd_supply_q;
  assign o_BIAS_CIRCUIT_CODE = bias_circ_q;
  assign o_CONTRAST_CODE = contrast_q;
  assign o_BIAS_RESISTOR_CODE = bias_res_q;

  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RESET);

  sequence s_rd_addr;
    byte_done && state_q == lcd_decoder_pkg::S_ADDR && rd_mode_q;
  endsequence
  soft_reset_a: assert property (soft_rst |=> drive_q == 8'hF7 && !osc_on_q && bias_res_q == 2'h2)
    else $error("soft reset did not restore defaults");
  ram_write_a: assert property (ram_we |=> state_q == lcd_decoder_pkg::S_IGNORE || !cs_act)
    else $error("ram write outside data byte");
  addr_drop_a: assert property (byte_done && state_q == lcd_decoder_pkg::S_WDATA && !addr_ok |=>
    $stable(u_ram.mem[{acc_page_q, addr_q}]))
    else $error("out of range write reached ram");
  read_out_a: assert property (s_rd_addr ##1 cs_act [*2] |-> oe_q && tx_q == $past(ram_rdata))
    else $error("read data not driven");
  page_sel_a: assert property (param_done && cmd_q == `CMD_PAGE_SEL |=> page_select_q == $past(byte_in[0]))
    else $error("page select not stored");
  bias_keep_a: assert property (param_done && cmd_q == `CMD_BIAS_CIRC && byte_in[1:0] == 2'h2 |=> $stable(bias_circ_q))
    else $error("invalid bias circuit code taken");
  lcd_off_a: assert property (!osc_on_q |=> !lcd_active_q)
    else $error("display active with oscillator off");
  cmd_first_a: assert property (is_cmd && byte_in == `CMD_WR_PAGE0 |=> state_q == lcd_decoder_pkg::S_ADDR || !cs_act)
    else $error("write command not followed by address");
endmodule
`default_nettype wire

// ---- sim/link_host_model.sv ----
/*
  Host model for the 3-wire serial link: frames of command and parameter
  bytes, msb first, with an optional read byte at the end.
  Assumes the bench resolves the shared data line and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
  // link pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_dio,
  // resolved data line
  input wire logic i_dio_line,
  // bench clock, used only to keep pin changes off its edges
  input wire logic i_clk
);
  localparam real HALF = 62.5;
  // 1.25 ns past a falling edge, every multiple of HALF falls between clock edges
  localparam real SKEW = 1.25;

  // idle: deselected, clock parked low between frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_dio = 1'b0;
  end

  // one frame: first byte is the command, then its parameters in order
  task automatic xfer(input logic [23:0] b, input int n, input bit rd, output logic [7:0] q);
    int i;
    q = 8'h00;
    @(negedge i_clk);
    #(SKEW);
    o_cs_n = 1'b0;
    for (i = 0; i < 8 * n; i++) begin
      o_dio = b[23-i];
      #(HALF);
      o_sclk = 1'b1;
      #(HALF);
      o_sclk = 1'b0;
    end
    // released line shows the inverse so a stale bit cannot pass
    o_dio = ~o_dio;
    if (rd) begin
      for (i = 0; i < 8; i++) begin
        #(HALF);
        q = {q[6:0], i_dio_line};
        o_sclk = 1'b1;
        #(HALF);
        o_sclk = 1'b0;
      end
    end
    #(HALF);
    o_cs_n = 1'b1;
    #(4 * HALF);
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
/*
  Self-checking bench for the LCD command decoder: settings, display RAM,
  page select, general outputs, PWM and soft reset.
  Assumes the link host model drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic clk;
  logic rst;
  logic [7:0] scan_addr;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wire logic cs_n, sclk, host_dio, dio_line, dev_dio, dev_oe, page, wave, osc, disp, active;
  wire logic pump_src, reg_en, pump_en, supply;
  wire logic [7:0] scan_data;
  wire logic [3:0] duty, frame, gpo, contrast;
  wire logic [2:0] bias, ratio;
  wire logic [1:0] blink, bcc, bres;
  wire logic [4:0] reg_lvl;
  wire logic [36:0] settings;
  localparam logic [36:0] DEFAULTS = {1'h0, 4'hF, 3'h7, 3'h0, 4'hA, 2'h0, 2'h0, 5'h00, 4'h0, 1'h0, 2'h0, 4'h0, 2'h2};

  // shared data line: device wins while it drives
  assign dio_line = dev_oe ? dev_dio : host_dio;
  assign settings = {page, duty, bias, wave, osc, disp, frame, blink, pump_src, reg_en, reg_lvl,
                     pump_en, ratio, supply, bcc, contrast, bres};

  lcd_driver_command_decoder u_dut (
    .I_REF_CLK(clk), .I_RESET(rst), .i_CS_N(cs_n), .i_LINK_CLK(sclk), .i_LINK_DIO(dio_line),
    .o_LINK_DIO(dev_dio), .o_LINK_DIO_OE(dev_oe), .i_SCAN_ADDR(scan_addr), .o_SCAN_DATA(scan_data),
    .o_PAGE_SELECT(page), .o_DUTY_CODE(duty), .o_BIAS_CODE(bias), .o_WAVEFORM_SELECT(wave),
    .o_OSC_ON(osc), .o_DISPLAY_ON(disp), .o_LCD_ACTIVE(active), .o_FRAME_RATE_CODE(frame),
    .o_BLINK_CODE(blink), .o_GENERAL_OUTPUT(gpo), .o_PUMP_SOURCE_SELECT(pump_src),
    .o_REGULATOR_ENABLE(reg_en), .o_REGULATOR_LEVEL(reg_lvl), .o_PUMP_ENABLE(pump_en),
    .o_PUMP_RATIO(ratio), .o_LCD_SUPPLY_SELECT(supply), .o_BIAS_CIRCUIT_CODE(bcc),
    .o_CONTRAST_CODE(contrast), .o_BIAS_RESISTOR_CODE(bres));

  link_host_model u_host (.o_cs_n(cs_n), .o_sclk(sclk), .o_dio(host_dio), .i_dio_line(dio_line), .i_clk(clk));

  // 100 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard, well above the longest pwm measurement
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] p);
    logic [7:0] q;
    u_host.xfer({c, p, 8'h00}, 2, 1'b0, q);
  endtask

  task automatic ram_rd(input logic [7:0] c, input logic [7:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] q;
    u_host.xfer({c, a, 8'h00}, 2, 1'b1, q);
    `CHK(nm, exp, q)
  endtask

  task automatic scan_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    scan_addr = a;
    repeat (2) @(negedge clk);
    `CHK("scan data", exp, scan_data)
  endtask

  task automatic check_defaults();
    `CHK("settings", DEFAULTS, settings)
    `CHK("lcd active", 1'h0, active)
    `CHK("dio enable", 1'h0, dev_oe)
  endtask

  // page 0 access at 1/16 duty, top legal address included
  task automatic ram_page0();
    logic [7:0] q;
    u_host.xfer({8'h80, 8'h44, 8'h11}, 3, 1'b0, q);
    u_host.xfer({8'h80, 8'h77, 8'hA5}, 3, 1'b0, q);
    ram_rd(8'h81, 8'h77, 8'hA5, "rd page0 77");
    ram_rd(8'h81, 8'h44, 8'h11, "rd page0 44");
  endtask

  // every setting command except page select, gpo and pwm ones, plus an undefined bias circuit code
  task automatic settings_all();
    logic [7:0] cmds [11] = '{8'h82, 8'h84, 8'h86, 8'h88, 8'h8A, 8'hC0, 8'hC2, 8'hD0, 8'hD2, 8'hD4, 8'hD0};
    logic [7:0] pars [11] = '{8'h74, 8'h01, 8'h03, 8'h0F, 8'h03, 8'hDF, 8'hB0, 8'h13, 8'h09, 8'h01, 8'h12};
    for (int i = 0; i < 11; i++) cmd(cmds[i], pars[i]);
    `CHK("settings", {1'h0, 4'h7, 3'h4, 3'h7, 4'hF, 2'h3, 2'h3, 5'h1F, 4'hB, 1'h1, 2'h3, 4'h9, 2'h1}, settings)
    `CHK("lcd active", 1'h1, active)
  endtask

  // duty now 1/8: page 1 allowed, address limit 43h
  task automatic ram_pages();
    logic [7:0] q;
    u_host.xfer({8'h80, 8'h44, 8'h22}, 3, 1'b0, q);
    ram_rd(8'h81, 8'h44, 8'h11, "dropped write");
    u_host.xfer({8'h80, 8'h05, 8'hC3}, 3, 1'b0, q);
    u_host.xfer({8'h70, 8'h05, 8'h5A}, 3, 1'b0, q);
    u_host.xfer({8'h70, 8'h43, 8'h7E}, 3, 1'b0, q);
    ram_rd(8'h71, 8'h05, 8'h5A, "rd page1 05");
    ram_rd(8'h71, 8'h43, 8'h7E, "rd page1 43");
    ram_rd(8'h81, 8'h05, 8'hC3, "rd page0 05");
    scan_chk(8'h05, 8'hC3);
    cmd(8'h72, 8'h01);
    `CHK("page select", 1'h1, page)
    scan_chk(8'h05, 8'h5A);
  endtask

  // binary pins, one pwm pin, then oscillator off
  task automatic gpo_pwm();
    int hi;
    int per;
    cmd(8'h90, 8'h0A);
    `CHK("gpo binary", 4'hA, gpo)
    cmd(8'h92, 8'h01);
    cmd(8'hB0, 8'h01);
    cmd(8'hB2, 8'h00);
    `CHK("gpo keep", 3'h5, gpo[3:1])
    hi = 0;
    per = 0;
    while (gpo[0] !== 1'b0 && per < 30000) begin @(negedge clk); per++; end
    while (gpo[0] !== 1'b1 && per < 30000) begin @(negedge clk); per++; end
    per = 0;
    while (gpo[0] === 1'b1 && per < 30000) begin @(negedge clk); hi++; per++; end
    while (gpo[0] !== 1'b1 && per < 30000) begin @(negedge clk); per++; end
    `CHK("pwm min high", per, hi * 64)
    cmd(8'hB2, 8'h3F);
    hi = 0;
    repeat (1000) begin @(negedge clk); if (gpo[0] !== 1'b1) hi++; end
    `CHK("pwm full low count", 0, hi)
    cmd(8'h86, 8'h00);
    repeat (4) @(negedge clk);
    `CHK("osc off gpo", 4'hA, gpo)
    `CHK("osc off active", 1'h0, active)
  endtask

  // extra byte ignored, then soft reset
  task automatic extra_and_reset();
    logic [7:0] q;
    u_host.xfer({8'h8A, 8'h01, 8'h02}, 3, 1'b0, q);
    `CHK("blink", 2'h1, blink)
    u_host.xfer({8'hAA, 16'h0000}, 1, 1'b0, q);
    check_defaults();
    `CHK("gpo after reset", 4'h0, gpo)
  endtask

  // reset, then scenarios in order
  initial begin
    rst = 1'b1;
    scan_addr = 8'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    check_defaults();
    ram_page0();
    settings_all();
    ram_pages();
    gpo_pwm();
    extra_and_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
